/* File: rtl/pcr_regs.v */
// protection configuration registers and the fault policy they steer
`include "pcr_consts.vh"

// Functional notes
// - Overcurrent mask bit blocks overcurrent from fault logic; status flag still sets.
// - First register bit 6 with companion bit sets power-enable output polarity.
// - First register bit 5 with companion bit sets breaker-drive polarity.
// - Fast ride-through bit selects the short microsecond ride-through range.
// - Field bits 4-3: 1..4 seconds slow, or 128..512 microseconds fast.
// - Bit 1 of first register removes ground-continuity input from debounce.
// - Bit 0 of first register: 0 nonlatching breaker drive, 1 latching.
// - Auto-restart set: retry start every second after undervoltage or overcurrent.
// - Auto-restart clear: faults latch until power-on request cycles or power removed.
// - Second register bit 6: mains-good passes directly, or host gates it.
// - Write-only bit 2 picks first or second mains-sense input for mains-good.
// - Power-on defaults of both registers load from nonvolatile store at power-up.
// - Trim-lock set rejects bus writes until the store is erased and reloaded.
module pcr_regs (
    CLK_SYS,
    RST,
    NV_LOAD,
    NV_CFG_A,
    NV_CFG_B,
    TRIM_LOCK,
    WR_EN,
    RD_EN,
    ADDR,
    WDATA,
    RDATA,
    WR_REJECT,
    POL_PEN_HI,
    POL_BRK_HI,
    OC_EVENT,
    UV_EVENT,
    PSON_IN,
    GND_OK_IN,
    MAINS_SENSE1,
    MAINS_SENSE2,
    OC_STATUS,
    FAULT_LATCHED,
    RIDETHROUGH_ACTIVE,
    RESTART_PULSE,
    GND_OK_DEBOUNCE,
    MAINS_SENSE_OK,
    PSON_REQ,
    POWER_ENABLE_OUTPUT,
    BREAKER_DRIVE,
    BRK_CLEAR
);
    input wire CLK_SYS;
    input wire RST;
    input wire NV_LOAD;
    input wire [7:0] NV_CFG_A;
    input wire [7:0] NV_CFG_B;
    input wire TRIM_LOCK;
    input wire WR_EN;
    input wire RD_EN;
    input wire [7:0] ADDR;
    input wire [7:0] WDATA;
    output reg [7:0] RDATA;
    output reg WR_REJECT;
    input wire POL_PEN_HI;
    input wire POL_BRK_HI;
    input wire OC_EVENT;
    input wire UV_EVENT;
    input wire PSON_IN;
    input wire GND_OK_IN;
    input wire MAINS_SENSE1;
    input wire MAINS_SENSE2;
    output reg OC_STATUS;
    output reg FAULT_LATCHED;
    output reg RIDETHROUGH_ACTIVE;
    output reg RESTART_PULSE;
    output reg GND_OK_DEBOUNCE;
    output reg MAINS_SENSE_OK;
    output reg PSON_REQ;
    output reg POWER_ENABLE_OUTPUT;
    output reg BREAKER_DRIVE;
    input wire BRK_CLEAR;

    // ============================================================
    // registers
    reg [7:0] cfg_a_q;
    reg [7:0] cfg_b_q;
    reg host_mains_w_q;
    reg host_pson_w_q;
    reg mains_src_q;
    reg pson_d1_q;
    reg oc_hold_q;
    wire wr_a;
    wire wr_b;
    wire locked;
    wire oc_fault;
    wire any_fault;
    wire rt_done;
    wire rs_done;
    wire [31:0] rt_load;
    wire pson_eff;
    wire mains_good;
    reg [31:0] rt_slow;

    assign locked = TRIM_LOCK;
    assign wr_a = WR_EN && ADDR == `PCR_OFS_CFG_A && !locked;
    assign wr_b = WR_EN && ADDR == `PCR_OFS_CFG_B && !locked;

    // ============================================================
    // register writes; nonvolatile download wins over a bus write
    always @(posedge CLK_SYS or posedge RST) begin
        if (RST) begin
            cfg_a_q <= 8'h00;
            cfg_b_q <= 8'h00;
            host_mains_w_q <= 1'b0;
            host_pson_w_q <= 1'b0;
            mains_src_q <= 1'b0;
            WR_REJECT <= 1'b0;
        end else begin
            WR_REJECT <= WR_EN && locked &&
                (ADDR == `PCR_OFS_CFG_A || ADDR == `PCR_OFS_CFG_B);
            if (NV_LOAD) begin
                cfg_a_q <= NV_CFG_A & `PCR_A_RW_MASK;
                cfg_b_q <= NV_CFG_B;
                host_mains_w_q <= NV_CFG_B[`PCR_B_HOST_MAINS_W];
                host_pson_w_q <= NV_CFG_B[`PCR_B_HOST_PSON_W];
                mains_src_q <= NV_CFG_B[`PCR_B_MAINS_SRC];
            end else begin
                if (wr_a)
                    cfg_a_q <= WDATA & `PCR_A_RW_MASK;
                if (wr_b) begin
                    cfg_b_q <= WDATA;
                    host_mains_w_q <= WDATA[`PCR_B_HOST_MAINS_W];
                    host_pson_w_q <= WDATA[`PCR_B_HOST_PSON_W];
                    mains_src_q <= WDATA[`PCR_B_MAINS_SRC];
                end
            end
        end
    end

    // ============================================================
    // read path; write-only bits read as zero
    always @(posedge CLK_SYS or posedge RST) begin
        if (RST)
            RDATA <= 8'h00;
        else if (RD_EN && ADDR == `PCR_OFS_CFG_A)
            RDATA <= cfg_a_q;
        else if (RD_EN && ADDR == `PCR_OFS_CFG_B)
            RDATA <= cfg_b_q & `PCR_B_RD_MASK;
        else if (RD_EN)
            RDATA <= 8'h00;
    end

    // ============================================================
    // ride-through length per code; products kept 32 bits wide
    always @* begin
        case (cfg_b_q[`PCR_B_RT_HI:`PCR_B_RT_LO])
            2'h0: rt_slow = `PCR_RT_SLOW_CYC;
            2'h1: rt_slow = 2 * `PCR_RT_SLOW_CYC;
            2'h2: rt_slow = 3 * `PCR_RT_SLOW_CYC;
            default: rt_slow = 4 * `PCR_RT_SLOW_CYC;
        endcase
    end
    assign rt_load = cfg_a_q[`PCR_A_FAST_RT] ?
        ({30'h0, cfg_b_q[`PCR_B_RT_HI:`PCR_B_RT_LO]} + 32'h1) * `PCR_RT_FAST_CYC :
        rt_slow;

    // overcurrent must persist through the ride-through before it is a fault
    pcr_timer u_rt (
        .clk(CLK_SYS),
        .rst(RST),
        .start(OC_EVENT && !oc_hold_q),
        .run(OC_EVENT),
        .load(rt_load),
        .done(rt_done)
    );

    assign oc_fault = rt_done && !cfg_a_q[`PCR_A_OC_MASK];
    assign any_fault = oc_fault || UV_EVENT;

    pcr_timer u_rs (
        .clk(CLK_SYS),
        .rst(RST),
        .start(!FAULT_LATCHED || !cfg_b_q[`PCR_B_AUTO_RESTART] || rs_done),
        .run(1'b1),
        .load(`PCR_RESTART_CYC),
        .done(rs_done)
    );

    assign pson_eff = PSON_IN || host_pson_w_q;
    assign mains_good = mains_src_q ? MAINS_SENSE2 : MAINS_SENSE1;

    // ============================================================
    // fault policy and outputs
    always @(posedge CLK_SYS or posedge RST) begin
        if (RST) begin
            oc_hold_q <= 1'b0;
            pson_d1_q <= 1'b0;
            OC_STATUS <= 1'b0;
            FAULT_LATCHED <= 1'b0;
            RIDETHROUGH_ACTIVE <= 1'b0;
            RESTART_PULSE <= 1'b0;
            GND_OK_DEBOUNCE <= 1'b0;
            MAINS_SENSE_OK <= 1'b0;
            PSON_REQ <= 1'b0;
            POWER_ENABLE_OUTPUT <= 1'b0;
            BREAKER_DRIVE <= 1'b0;
        end else begin
            oc_hold_q <= OC_EVENT;
            pson_d1_q <= pson_eff;
            RIDETHROUGH_ACTIVE <= OC_EVENT && !rt_done;
            OC_STATUS <= OC_STATUS || rt_done;
            // a new fault wins over any clear in the same cycle
            if (any_fault)
                FAULT_LATCHED <= 1'b1;
            else if (cfg_b_q[`PCR_B_AUTO_RESTART] && rs_done)
                FAULT_LATCHED <= 1'b0;
            else if (pson_d1_q && !pson_eff)
                FAULT_LATCHED <= 1'b0;
            RESTART_PULSE <= cfg_b_q[`PCR_B_AUTO_RESTART] && rs_done && !any_fault;
            GND_OK_DEBOUNCE <= GND_OK_IN || cfg_a_q[`PCR_A_GND_DIS];
            MAINS_SENSE_OK <= cfg_b_q[`PCR_B_HOST_MAINS] ?
                (mains_good && host_mains_w_q) : mains_good;
            PSON_REQ <= pson_eff;
            // polarity: only an xor of the two bits is used, table omitted
            POWER_ENABLE_OUTPUT <= (pson_eff && !FAULT_LATCHED && !any_fault) ^
                (cfg_a_q[`PCR_A_PEN_POL] ^ POL_PEN_HI);
            if (cfg_a_q[`PCR_A_BRK_LATCH]) begin
                if (any_fault)
                    BREAKER_DRIVE <= 1'b1 ^ (cfg_a_q[`PCR_A_BRK_POL] ^ POL_BRK_HI);
                else if (BRK_CLEAR)
                    BREAKER_DRIVE <= cfg_a_q[`PCR_A_BRK_POL] ^ POL_BRK_HI;
            end else begin
                BREAKER_DRIVE <= any_fault ^ (cfg_a_q[`PCR_A_BRK_POL] ^ POL_BRK_HI);
            end
        end
    end
endmodule // pcr_regs

/* File: rtl/pcr_consts.vh */
// constants for the protection configuration register bank
`ifndef PCR_CONSTS_VH
`define PCR_CONSTS_VH
// ============================================================
// register offsets
`define PCR_OFS_CFG_A 8'h11
`define PCR_OFS_CFG_B 8'h12
// ============================================================
// field positions, register a
`define PCR_A_OC_MASK 7
`define PCR_A_PEN_POL 6
`define PCR_A_BRK_POL 5
`define PCR_A_FAST_RT 2
`define PCR_A_GND_DIS 1
`define PCR_A_BRK_LATCH 0
`define PCR_A_RW_MASK 8'hE7
// ============================================================
// field positions, register b
`define PCR_B_AUTO_RESTART 7
`define PCR_B_HOST_MAINS 6
`define PCR_B_HOST_MAINS_W 5
`define PCR_B_RT_HI 4
`define PCR_B_RT_LO 3
`define PCR_B_MAINS_SRC 2
`define PCR_B_HOST_PSON_W 1
`define PCR_B_SHARE_CLAMP 0
`define PCR_B_RD_MASK 8'hD9
// ============================================================
// timing, clock 25 MHz
`define PCR_CLK_HZ 25000000
`define PCR_RT_SLOW_S 1
`define PCR_RT_FAST_US 128
`define PCR_RESTART_S 1
`define PCR_RT_SLOW_CYC (`PCR_RT_SLOW_S * `PCR_CLK_HZ)
// divide first: the plain product would overflow a 32-bit integer
`define PCR_RT_FAST_CYC (`PCR_RT_FAST_US * (`PCR_CLK_HZ / 1000000))
`define PCR_RESTART_CYC (`PCR_RESTART_S * `PCR_CLK_HZ)
`endif

/* File: rtl/pcr_timer.v */
// down counter used for ride-through and restart intervals
`include "pcr_consts.vh"

module pcr_timer (
    input wire clk,
    input wire rst,
    input wire start,
    input wire run,
    input wire [31:0] load,
    output reg done
);
    reg [31:0] cnt_q;
    // ============================================================
    // counter: load on start, count while run, pulse done at one
    always @(posedge clk or posedge rst) begin
        if (rst) begin
            cnt_q <= 32'h00000000;
            done <= 1'b0;
        end else if (start) begin
            cnt_q <= load;
            done <= 1'b0;
        end else if (run && cnt_q != 32'h00000000) begin
            cnt_q <= cnt_q - 32'h00000001;
            done <= (cnt_q == 32'h00000001);
        end else begin
            done <= 1'b0;
        end
    end
endmodule // pcr_timer

/* File: verif/pcr_checker.sv */
// assertion checker for the protection configuration registers
`include "pcr_consts.vh"
module pcr_checker (
    input wire CLK_SYS,
    input wire RST,
    input wire TRIM_LOCK,
    input wire WR_EN,
    input wire RD_EN,
    input wire [7:0] ADDR,
    input wire [7:0] RDATA,
    input wire WR_REJECT,
    input wire OC_EVENT,
    input wire UV_EVENT,
    input wire OC_STATUS,
    input wire FAULT_LATCHED,
    input wire RESTART_PULSE
);
    timeunit 1ns;
    timeprecision 100ps;
    // ============================================================
    // helper: cycles of unbroken overcurrent, saturating
    logic [15:0] oc_run_q;
    always @(posedge CLK_SYS or posedge RST) begin
        if (RST) oc_run_q <= 16'h0000;
        else oc_run_q <= OC_EVENT ? oc_run_q + {15'h0000, ~&oc_run_q} : 16'h0000;
    end
    default clocking @(posedge CLK_SYS); endclocking
    default disable iff (RST);
    // ============================================================
    // assertions
    a_unmapped_read: assert property (RD_EN && ADDR != 8'h11 && ADDR != 8'h12 |=> RDATA == 8'h00)
        else $error("unmapped read not zero");
    a_reserved_a_zero: assert property (RD_EN && ADDR == 8'h11 |=> (RDATA & 8'h18) == 8'h00)
        else $error("reserved bits of register a read nonzero");
    a_write_only_zero: assert property (RD_EN && ADDR == 8'h12 |=> (RDATA & 8'h26) == 8'h00)
        else $error("write-only bits of register b read nonzero");
    a_locked_reject: assert property (WR_EN && TRIM_LOCK && (ADDR == 8'h11 || ADDR == 8'h12)
        |=> WR_REJECT)
        else $error("locked write not refused");
    a_reject_cause: assert property (WR_REJECT |-> $past(WR_EN) && $past(TRIM_LOCK))
        else $error("refusal without locked write");
    a_rdata_hold: assert property (!RD_EN |=> $stable(RDATA))
        else $error("read data moved without read");
    a_oc_sticky: assert property (OC_STATUS |=> OC_STATUS)
        else $error("overcurrent status dropped");
    a_fault_ride: assert property ($rose(FAULT_LATCHED) |-> oc_run_q >= 16'd3199
        || UV_EVENT || $past(UV_EVENT))
        else $error("fault before ride-through elapsed");
    a_restart_single: assert property (RESTART_PULSE |=> !RESTART_PULSE)
        else $error("restart pulse longer than a cycle");
    c_reject: cover property (WR_REJECT);
    c_fault: cover property ($rose(FAULT_LATCHED));
    c_read_b: cover property (RD_EN && ADDR == 8'h12);
endmodule // pcr_checker

bind pcr_regs pcr_checker pcr_checker_inst (.CLK_SYS(CLK_SYS), .RST(RST),
    .TRIM_LOCK(TRIM_LOCK), .WR_EN(WR_EN), .RD_EN(RD_EN), .ADDR(ADDR), .RDATA(RDATA),
    .WR_REJECT(WR_REJECT), .OC_EVENT(OC_EVENT), .UV_EVENT(UV_EVENT), .OC_STATUS(OC_STATUS),
    .FAULT_LATCHED(FAULT_LATCHED), .RESTART_PULSE(RESTART_PULSE));

/* File: verif/tb.sv */
// self-checking bench for the protection configuration registers
`include "pcr_consts.vh"
module tb;
    timeunit 1ns;
    timeprecision 100ps;
    logic CLK_SYS = 0, RST = 1, NV_LOAD = 0, TRIM_LOCK = 0, WR_EN = 0, RD_EN = 0;
    logic [7:0] NV_CFG_A = 8'h00, NV_CFG_B = 8'h00, ADDR = 8'h00, WDATA = 8'h00;
    logic OC_EVENT = 0, PSON_IN = 1, GND_OK_IN = 1, MAINS_SENSE1 = 0, MAINS_SENSE2 = 0;
    logic POL_PEN_HI = 0, POL_BRK_HI = 0, UV_EVENT = 0, BRK_CLEAR = 0;
    wire [7:0] RDATA;
    wire WR_REJECT, OC_STATUS, FAULT_LATCHED, RESTART_PULSE, GND_OK_DEBOUNCE, MAINS_SENSE_OK;
    wire RIDETHROUGH_ACTIVE, PSON_REQ, POWER_ENABLE_OUTPUT, BREAKER_DRIVE;
    integer err_total = 0, cmp_count = 0, ra = 0, rb = 0, k, n, s;
    pcr_regs pcr_regs_inst (.CLK_SYS(CLK_SYS), .RST(RST), .NV_LOAD(NV_LOAD),
        .NV_CFG_A(NV_CFG_A), .NV_CFG_B(NV_CFG_B), .TRIM_LOCK(TRIM_LOCK), .WR_EN(WR_EN),
        .RD_EN(RD_EN), .ADDR(ADDR), .WDATA(WDATA), .RDATA(RDATA), .WR_REJECT(WR_REJECT),
        .POL_PEN_HI(POL_PEN_HI), .POL_BRK_HI(POL_BRK_HI), .OC_EVENT(OC_EVENT),
        .UV_EVENT(UV_EVENT), .PSON_IN(PSON_IN), .GND_OK_IN(GND_OK_IN),
        .MAINS_SENSE1(MAINS_SENSE1), .MAINS_SENSE2(MAINS_SENSE2), .OC_STATUS(OC_STATUS),
        .FAULT_LATCHED(FAULT_LATCHED), .RIDETHROUGH_ACTIVE(RIDETHROUGH_ACTIVE),
        .RESTART_PULSE(RESTART_PULSE), .GND_OK_DEBOUNCE(GND_OK_DEBOUNCE),
        .MAINS_SENSE_OK(MAINS_SENSE_OK), .PSON_REQ(PSON_REQ),
        .POWER_ENABLE_OUTPUT(POWER_ENABLE_OUTPUT), .BREAKER_DRIVE(BREAKER_DRIVE),
        .BRK_CLEAR(BRK_CLEAR));
    initial forever #20 CLK_SYS = ~CLK_SYS;
    // ============================================================
    // shared tasks
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        cmp_count++;
        if (got !== exp) begin
            err_total++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic tick(input integer c);
        repeat (c) @(posedge CLK_SYS);
        #2;
    endtask
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        ADDR = a;
        WDATA = d;
        WR_EN = 1'h1;
        tick(1);
        WR_EN = 1'h0;
        chk(WR_REJECT, TRIM_LOCK && (a == 8'h11 || a == 8'h12));
        if (!TRIM_LOCK && a == 8'h11) ra = d;
        if (!TRIM_LOCK && a == 8'h12) rb = d;
    endtask
    task automatic rd(input logic [7:0] a);
        ADDR = a;
        RD_EN = 1'h1;
        tick(1);
        RD_EN = 1'h0;
        chk(RDATA, a == 8'h11 ? ra & 8'hE7 : a == 8'h12 ? rb & 8'hD9 : 8'h00);
    endtask
    task automatic wrap_up;
        $display("compares %0d errors %0d", cmp_count, err_total);
        if (err_total == 0 && cmp_count > 0) $display("Simulation passed");
        else $display("Simulation failed");
        $finish;
    endtask
    // ============================================================
    // watchdog: ride-through loop needs about 35300 cycles
    initial begin
        tick(60000);
        err_total++;
        wrap_up;
    end
    // ============================================================
    // main sequence
    initial begin
        void'($urandom(32'h87003C2B));
        tick(8);
        RST = 1'h0;
        tick(1);
        NV_CFG_A = $urandom;
        NV_CFG_B = $urandom;
        NV_LOAD = 1'h1;
        ra = NV_CFG_A;
        rb = NV_CFG_B;
        tick(1);
        NV_LOAD = 1'h0;
        rd(8'h11);
        rd(8'h12);
        for (k = 0; k < 24; k++) begin
            TRIM_LOCK = ($urandom % 4) == 0;
            wr(8'h10 + $urandom % 4, $urandom);
            rd(8'h11);
            rd(8'h12);
            rd(8'h13);
        end
        TRIM_LOCK = 1'h0;
        for (k = 0; k < 8; k++) begin
            wr(8'h12, {1'h0, k[1], k[2], 2'h0, k[0], 2'h0});
            MAINS_SENSE1 = $urandom;
            MAINS_SENSE2 = $urandom;
            tick(4);
            s = k[0] ? MAINS_SENSE2 : MAINS_SENSE1;
            chk(MAINS_SENSE_OK, k[1] ? s & k[2] : s);
        end
        wr(8'h11, 8'h02);
        GND_OK_IN = 1'h0;
        tick(4);
        chk(GND_OK_DEBOUNCE, 8'h01);
        wr(8'h11, 8'h00);
        tick(2);
        chk(GND_OK_DEBOUNCE, 8'h00);
        GND_OK_IN = 1'h1;
        // pass 0 masked at shortest period, then codes 0..3 unmasked
        for (k = 0; k < 5; k++) begin
            n = 3200 * (k == 0 ? 1 : k);
            wr(8'h11, k == 0 ? 8'h84 : 8'h04);
            wr(8'h12, k == 0 ? 8'h00 : (k - 1) << 3);
            OC_EVENT = 1'h1;
            tick(n - 3);
            chk(FAULT_LATCHED, 8'h00);
            chk(RIDETHROUGH_ACTIVE, 8'h01);
            tick(8);
            chk(FAULT_LATCHED, k != 0);
            chk(OC_STATUS, 8'h01);
            OC_EVENT = 1'h0;
            tick(2);
            chk(RIDETHROUGH_ACTIVE, 8'h00);
            PSON_IN = 1'h0;
            tick(4);
            chk(FAULT_LATCHED, 8'h00);
            PSON_IN = 1'h1;
        end
        // polarity, breaker latch on undervoltage, host power-on request
        for (k = 0; k < 8; k++) begin
            n = $urandom;
            wr(8'h11, {1'h0, n[1], n[2], 4'h0, k[0]});
            POL_PEN_HI = n[3];
            POL_BRK_HI = n[4];
            BRK_CLEAR = 1'h1;
            tick(2);
            BRK_CLEAR = 1'h0;
            chk(POWER_ENABLE_OUTPUT, n[1] ^ n[3] ^ 1'h1);
            chk(BREAKER_DRIVE, n[2] ^ n[4]);
            UV_EVENT = 1'h1;
            tick(2);
            chk(BREAKER_DRIVE, n[2] ^ n[4] ^ 1'h1);
            chk(POWER_ENABLE_OUTPUT, n[1] ^ n[3]);
            UV_EVENT = 1'h0;
            tick(2);
            chk(BREAKER_DRIVE, n[2] ^ n[4] ^ k[0]);
            BRK_CLEAR = 1'h1;
            tick(1);
            BRK_CLEAR = 1'h0;
            chk(BREAKER_DRIVE, n[2] ^ n[4]);
            chk(FAULT_LATCHED, 8'h01);
            PSON_IN = 1'h0;
            tick(2);
            chk(FAULT_LATCHED, 8'h00);
            chk(PSON_REQ, 8'h00);
            wr(8'h12, 8'h02);
            tick(2);
            chk(PSON_REQ, 8'h01);
            chk(POWER_ENABLE_OUTPUT, n[1] ^ n[3] ^ 1'h1);
            wr(8'h12, 8'h00);
            PSON_IN = 1'h1;
        end
        wrap_up;
    end
endmodule // tb
